//--- bst_defines.svh
// Purpose: Constants for the boundary-scan test port
// Assumes: Four-bit instruction register
// Notes:   Opcodes, widths, offsets and counts, no logic
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH
`define BST_IR_W        4
`define BST_OP_EXTEST   4'h0
`define BST_OP_IDCODE   4'h1
`define BST_OP_SAMPLE   4'h2
`define BST_OP_DEVRST   4'hc
`define BST_OP_BYPASS   4'hf
`define BST_IR_CAPTURE  4'h1
`define BST_ID_W        32
`define BST_REV_W       4
`define BST_PART_W      16
`define BST_MFR_W       11
`define BST_ID_MARK     1'h1
`define BST_CELLS       4
`define BST_CELL_ID     0
`define BST_CELL_OD     1
`define BST_CELL_OC     2
`define BST_CELL_PUD    3
`define BST_SU_SHORT    16
`define BST_SU_LONG     256
`endif

//--- bst_pkg.sv
// Purpose: Types for the boundary-scan test port
// Assumes: Standard sixteen-state TAP controller
// Notes:   Constants live in bst_defines.svh
package bst_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SELDR, CAPDR, SHDR, EX1DR, PAUSEDR, EX2DR, UPDR,
    SELIR, CAPIR, SHIR, EX1IR, PAUSEIR, EX2IR, UPIR
  } bst_tap_state_type;
  typedef struct packed {
    logic pud;
    logic oe;
    logic out;
  } bst_drive_type;
endpackage : bst_pkg

//--- bst_tap.sv
// Purpose: Boundary-scan TAP, instruction and data registers
// Assumes: TAP logic on tck, reset logic on ref_clk
// Notes:   Pin drives are muxed, not registered, so that
//          a stopped chip clock still lets the chain drive
`timescale 1ns/1ns
`default_nettype none
`include "bst_defines.svh"
module bst_tap #(
  parameter int          NUM_PINS   = 8,
  parameter int          SU_SHORT   = `BST_SU_SHORT,
  parameter int          SU_LONG    = `BST_SU_LONG,
  // Identity values are arbitrary
  parameter logic [3:0]  ID_REV     = 4'h3,
  parameter logic [15:0] ID_PART    = 16'h5a3c,
  parameter logic [10:0] ID_MFR     = 11'h2b6
) (
  input  wire logic                ref_clk,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic                tck,
  input  wire logic                tms,
  input  wire logic                tdi,
  output logic                     tdo,
  output logic                     tdoOe,
  input  wire logic                testPortEnableFuse,
  input  wire logic                testPortDisableBit,
  input  wire logic                extResetN,
  input  wire logic                clkOptionLong,
  input  wire logic                flagWriteZero,
  input  wire logic [NUM_PINS-1:0] pinIn,
  input  wire logic [NUM_PINS-1:0] sysOut,
  input  wire logic [NUM_PINS-1:0] sysOe,
  input  wire logic [NUM_PINS-1:0] sysPullupDis,
  output logic [NUM_PINS-1:0]      pinOut,
  output logic [NUM_PINS-1:0]      pinOe,
  output logic [NUM_PINS-1:0]      pinPullupDis,
  output logic                     deviceReset,
  output logic                     testResetFlag
);
  localparam int CW = NUM_PINS * `BST_CELLS;

  // tck-domain synchronisers
  logic rstA_reg, rstB_reg;
  logic [1:0] enA_reg, enB_reg;
  logic [NUM_PINS-1:0] pinA_reg, pinB_reg;
  // Fuse and disable bit are static, a level crossing suffices
  wire  portEn = enB_reg[0] & ~enB_reg[1];
  wire  tckRst = rstB_reg | ~portEn;

  always_ff @(posedge tck) begin
    rstA_reg <= rst;
    rstB_reg <= rstA_reg;
    enA_reg  <= {testPortDisableBit, testPortEnableFuse};
    enB_reg  <= enA_reg;
    pinA_reg <= pinIn;
    pinB_reg <= pinA_reg;
  end

  // TAP controller
  bst_pkg::bst_tap_state_type state_reg, state_next;

  always_comb begin
    case (state_reg)
      bst_pkg::TLR:     state_next = tms ? bst_pkg::TLR : bst_pkg::RTI;
      bst_pkg::RTI:     state_next = tms ? bst_pkg::SELDR : bst_pkg::RTI;
      bst_pkg::SELDR:   state_next = tms ? bst_pkg::SELIR : bst_pkg::CAPDR;
      bst_pkg::CAPDR:   state_next = tms ? bst_pkg::EX1DR : bst_pkg::SHDR;
      bst_pkg::SHDR:    state_next = tms ? bst_pkg::EX1DR : bst_pkg::SHDR;
      bst_pkg::EX1DR:   state_next = tms ? bst_pkg::UPDR : bst_pkg::PAUSEDR;
      bst_pkg::PAUSEDR: state_next = tms ? bst_pkg::EX2DR : bst_pkg::PAUSEDR;
      bst_pkg::EX2DR:   state_next = tms ? bst_pkg::UPDR : bst_pkg::SHDR;
      bst_pkg::UPDR:    state_next = tms ? bst_pkg::SELDR : bst_pkg::RTI;
      bst_pkg::SELIR:   state_next = tms ? bst_pkg::TLR : bst_pkg::CAPIR;
      bst_pkg::CAPIR:   state_next = tms ? bst_pkg::EX1IR : bst_pkg::SHIR;
      bst_pkg::SHIR:    state_next = tms ? bst_pkg::EX1IR : bst_pkg::SHIR;
      bst_pkg::EX1IR:   state_next = tms ? bst_pkg::UPIR : bst_pkg::PAUSEIR;
      bst_pkg::PAUSEIR: state_next = tms ? bst_pkg::EX2IR : bst_pkg::PAUSEIR;
      bst_pkg::EX2IR:   state_next = tms ? bst_pkg::UPIR : bst_pkg::SHIR;
      bst_pkg::UPIR:    state_next = tms ? bst_pkg::SELDR : bst_pkg::RTI;
      default:          state_next = bst_pkg::TLR;
    endcase
  end

  always_ff @(posedge tck) begin
    if (tckRst) begin
      state_reg <= bst_pkg::TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  wire inTlr = state_reg == bst_pkg::TLR;
  wire capDr = state_reg == bst_pkg::CAPDR;
  wire shDr  = state_reg == bst_pkg::SHDR;
  wire upDr  = state_reg == bst_pkg::UPDR;
  wire capIr = state_reg == bst_pkg::CAPIR;
  wire shIr  = state_reg == bst_pkg::SHIR;
  wire upIr  = state_reg == bst_pkg::UPIR;

  // Instruction register
  logic [`BST_IR_W-1:0] irShift_reg, ir_reg;

  always_ff @(posedge tck) begin
    if (tckRst || inTlr) begin
      irShift_reg <= `BST_IR_CAPTURE;
      ir_reg      <= `BST_OP_IDCODE;
    end else begin
      if (capIr) begin
        irShift_reg <= `BST_IR_CAPTURE;
      end else if (shIr) begin
        irShift_reg <= {tdi, irShift_reg[`BST_IR_W-1:1]};
      end
      if (upIr) begin
        ir_reg <= irShift_reg;
      end
    end
  end

  // Decode; anything else falls to bypass
  wire extestSel = ir_reg == `BST_OP_EXTEST;
  wire sampleSel = ir_reg == `BST_OP_SAMPLE;
  wire idSel     = ir_reg == `BST_OP_IDCODE;
  wire rstSel    = ir_reg == `BST_OP_DEVRST;
  wire chainSel  = extestSel | sampleSel;
  wire bypassSel = ~(chainSel | idSel | rstSel);

  // Data registers
  wire [`BST_ID_W-1:0] idValue =
    {ID_REV, ID_PART, ID_MFR, `BST_ID_MARK};
  logic                 bypass_reg;
  logic                 resetBit_reg;
  logic [`BST_ID_W-1:0] idShift_reg;
  logic [CW-1:0]        chain_reg;
  bst_pkg::bst_drive_type latch_reg [NUM_PINS];
  logic [CW-1:0]        chainCap;

  always_ff @(posedge tck) begin
    if (capDr && bypassSel) begin
      bypass_reg <= 1'h0;
    end else if (shDr && bypassSel) begin
      bypass_reg <= tdi;
    end
  end

  always_ff @(posedge tck) begin
    if (capDr && idSel) begin
      idShift_reg <= idValue;
    end else if (shDr && idSel) begin
      idShift_reg <= {tdi, idShift_reg[`BST_ID_W-1:1]};
    end
  end

  // Only rst, synchronised to tck, or a zero shifted in under the reset opcode clears it; the TAP never resets it
  always_ff @(posedge tck) begin
    if (rstB_reg) begin
      resetBit_reg <= 1'h0;
    end else if (shDr && rstSel) begin
      resetBit_reg <= tdi;
    end
  end

  always_ff @(posedge tck) begin
    if (capDr && chainSel) begin
      chain_reg <= chainCap;
    end else if (shDr && chainSel) begin
      chain_reg <= {tdi, chain_reg[CW-1:1]};
    end
  end

  // Device reset seen by the pins, no clock in the path
  wire anyReset = deviceReset | resetBit_reg;

  genvar k;
  generate
    for (k = 0; k < NUM_PINS; k++) begin : g_pin
      localparam int B = k * `BST_CELLS;
      assign chainCap[B + `BST_CELL_ID]  = pinB_reg[k];
      assign chainCap[B + `BST_CELL_OD]  = latch_reg[k].out;
      assign chainCap[B + `BST_CELL_OC]  = latch_reg[k].oe;
      assign chainCap[B + `BST_CELL_PUD] = latch_reg[k].pud;

      always_ff @(posedge tck) begin
        if (tckRst) begin
          latch_reg[k] <= '0;
        end else if (upDr && chainSel) begin
          latch_reg[k].out <= chain_reg[B + `BST_CELL_OD];
          latch_reg[k].oe  <= chain_reg[B + `BST_CELL_OC];
          latch_reg[k].pud <= chain_reg[B + `BST_CELL_PUD];
        end
      end

      // Latches reach pins only under external test
      assign pinOut[k] = extestSel ? latch_reg[k].out
                                   : sysOut[k];
      assign pinOe[k]  = extestSel ? latch_reg[k].oe
                                   : sysOe[k] & ~anyReset;
      assign pinPullupDis[k] = extestSel ? latch_reg[k].pud
                                         : sysPullupDis[k] | anyReset;
    end
  endgenerate

  // Serial output on the falling edge
  wire drBit = chainSel ? chain_reg[0] :
               idSel    ? idShift_reg[0] :
               rstSel   ? resetBit_reg : bypass_reg;
  logic tdo_reg, tdoOe_reg;

  always_ff @(negedge tck) begin
    if (tckRst) begin
      tdo_reg   <= 1'h0;
      tdoOe_reg <= 1'h0;
    end else begin
      tdo_reg   <= shIr ? irShift_reg[0] : drBit;
      tdoOe_reg <= shIr | shDr;
    end
  end
  assign tdo   = tdo_reg;
  assign tdoOe = tdoOe_reg;

  // ref_clk domain: device reset and flag
  logic extA_reg, extB_reg, trA_reg, trB_reg;
  logic [15:0] suCnt_reg;
  logic        devRst_reg, flag_reg;
  wire  [15:0] suLoad = clkOptionLong ? 16'(SU_LONG)
                                      : 16'(SU_SHORT);
  wire         rstSrc = ~extB_reg | trB_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      extA_reg   <= 1'h1;
      extB_reg   <= 1'h1;
      trA_reg    <= 1'h0;
      trB_reg    <= 1'h0;
      suCnt_reg  <= 16'h0000;
      devRst_reg <= 1'h1;
      flag_reg   <= 1'h0;
    end else if (ce) begin
      extA_reg <= extResetN;
      extB_reg <= extA_reg;
      trA_reg  <= resetBit_reg;
      trB_reg  <= trA_reg;
      if (rstSrc) begin
        suCnt_reg <= suLoad;
      end else if (suCnt_reg != 16'h0000) begin
        suCnt_reg <= suCnt_reg - 16'h0001;
      end
      devRst_reg <= rstSrc | (suCnt_reg != 16'h0000);
      // Set beats the write of zero
      if (trB_reg) begin
        flag_reg <= 1'h1;
      end else if (flagWriteZero) begin
        flag_reg <= 1'h0;
      end
    end
  end
  assign deviceReset   = devRst_reg;
  assign testResetFlag = flag_reg;

  // Assertions, tck domain
  property p_tlr5;
    @(posedge tck) disable iff (tckRst) tms [*5] |=> inTlr;
  endproperty
  a_tlr5: assert property (p_tlr5)
    else $error("five tms highs did not reach reset");

  property p_irDefault;
    @(posedge tck) disable iff (tckRst) inTlr |=> idSel;
  endproperty
  a_irDefault: assert property (p_irDefault)
    else $error("id not default after reset state");

  property p_bypassCap;
    @(posedge tck) disable iff (tckRst)
      capDr && bypassSel |=> bypass_reg == 1'h0;
  endproperty
  a_bypassCap: assert property (p_bypassCap)
    else $error("bypass did not capture zero");

  property p_idCap;
    @(posedge tck) disable iff (tckRst)
      capDr && idSel |=> idShift_reg == idValue && idShift_reg[0];
  endproperty
  a_idCap: assert property (p_idCap)
    else $error("id capture wrong");

  property p_lsbFirst;
    @(posedge tck) disable iff (tckRst)
      shDr && idSel |=> idShift_reg[`BST_ID_W-1] == $past(tdi)
        && idShift_reg[`BST_ID_W-2:0] ==
           $past(idShift_reg[`BST_ID_W-1:1]);
  endproperty
  a_lsbFirst: assert property (p_lsbFirst)
    else $error("id shift order wrong");

  property p_rstHold;
    @(posedge tck) disable iff (tckRst)
      !(shDr && rstSel) |=> $stable(resetBit_reg);
  endproperty
  a_rstHold: assert property (p_rstHold)
    else $error("reset bit moved outside shift");

  property p_extestDrive;
    @(posedge tck) disable iff (tckRst)
      $rose(extestSel) |-> pinOut[0] == latch_reg[0].out
        && pinOe[0] == latch_reg[0].oe;
  endproperty
  a_extestDrive: assert property (p_extestDrive)
    else $error("latches not on pins under external test");

  property p_sampleIso;
    @(posedge tck) disable iff (tckRst)
      sampleSel |-> pinOut == sysOut;
  endproperty
  a_sampleIso: assert property (p_sampleIso)
    else $error("latches reached pins in sample mode");

  property p_unassigned;
    @(posedge tck) disable iff (tckRst)
      ir_reg inside {[4'h3:4'hb], 4'hd, 4'he} |-> bypassSel;
  endproperty
  a_unassigned: assert property (p_unassigned)
    else $error("unassigned opcode left bypass");

  property p_resetTri;
    @(posedge tck) disable iff (tckRst)
      resetBit_reg && !extestSel |-> pinOe == '0;
  endproperty
  a_resetTri: assert property (p_resetTri)
    else $error("pins driven during reset");

  // Assertions, ref_clk domain
  property p_flagSet;
    @(posedge ref_clk) disable iff (rst)
      ce && trB_reg |=> flag_reg && devRst_reg;
  endproperty
  a_flagSet: assert property (p_flagSet)
    else $error("test reset flag not set");

  property p_timeout;
    @(posedge ref_clk) disable iff (rst)
      ce && rstSrc |=> ce [*1] ##0 (!rstSrc) |=> devRst_reg;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("reset released without time-out");

  c_extest: cover property (@(posedge tck) upDr && extestSel);
  c_idShift: cover property (@(posedge tck) shDr && idSel);
  c_testRst: cover property (@(posedge ref_clk) $rose(flag_reg));
endmodule : bst_tap
`default_nettype wire

//--- bst_jtag_ctl.sv
// Purpose: Behavioural test controller on the far side of the port
// Assumes: Test clock of 15 ns, standing low between frames
// Notes:   Every scan starts and ends in Run-Test/Idle
`timescale 1ns/1ns
`default_nettype none
module bst_jtag_ctl (
  output var logic tck,
  output var logic tms,
  output var logic tdi,
  input  wire logic tdo,
  input  wire logic tdoOe,
  output var logic oeSeen
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    oeSeen = 1'b0;
  end

  // Sample just before the rising edge, where tdo has settled
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #7;
    // A released line shows the opposite of its last level
    q = tdoOe ? tdo : ~tdo;
    oeSeen = oeSeen | tdoOe;
    tck = 1'b1;
    #8;
    tck = 1'b0;
  endtask : step

  task automatic clrSeen();
    oeSeen = 1'b0;
  endtask : clrSeen

  task automatic tapReset();
    logic q;
    repeat (5) step(1'b1, tdi, q);
    step(1'b0, tdi, q);
  endtask : tapReset

  // Idle tdi flips so a stale bit is never mistaken for data
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic q;
    logic d;
    dout = 32'h0;
    step(1'b1, tdi, q);
    if (ir) step(1'b1, tdi, q);
    step(1'b0, tdi, q);
    step(1'b0, tdi, q);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], q);
      dout[i] = q;
    end
    d = ~din[n-1];
    step(1'b1, d, q);
    step(1'b0, d, q);
  endtask : scan
endmodule : bst_jtag_ctl
`default_nettype wire

//--- bst_tap_bench.sv
// Purpose: Self-checking bench for the boundary-scan test port
// Assumes: Short start-up counts so reset waits stay brief
// Notes:   Test clock comes from the controller model
`timescale 1ns/1ns
`default_nettype none
module bst_tap_bench;
  localparam int SU_S = 4;
  localparam int SU_L = 8;
  // Identity values are arbitrary
  localparam logic [3:0]  REV  = 4'h6;
  localparam logic [15:0] PART = 16'h2e4d;
  localparam logic [10:0] MFR  = 11'h15a;
  localparam logic [31:0] ID   = {REV, PART, MFR, 1'b1};
  logic            ref_clk, rst, ce, fuse, disBit, extResetN;
  logic            clkOptionLong, flagWriteZero;
  logic [7:0]      pinIn, sysOut, sysOe, sysPud;
  logic [31:0]     dout;
  wire logic       tck, tms, tdi, tdo, tdoOe, oeSeen;
  wire logic [7:0] pinOut, pinOe, pinPud;
  wire logic       deviceReset, testResetFlag;
  int              err_count;
  int              num_checks;

  bst_jtag_ctl bst_jtag_ctl_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdoOe(tdoOe), .oeSeen(oeSeen));
  bst_tap #(.NUM_PINS(8), .SU_SHORT(SU_S), .SU_LONG(SU_L), .ID_REV(REV),
    .ID_PART(PART), .ID_MFR(MFR)) bst_tap_i (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdoOe(tdoOe), .testPortEnableFuse(fuse),
    .testPortDisableBit(disBit), .extResetN(extResetN),
    .clkOptionLong(clkOptionLong), .flagWriteZero(flagWriteZero),
    .pinIn(pinIn), .sysOut(sysOut), .sysOe(sysOe), .sysPullupDis(sysPud),
    .pinOut(pinOut), .pinOe(pinOe), .pinPullupDis(pinPud),
    .deviceReset(deviceReset), .testResetFlag(testResetFlag));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic give_verdict();
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic waitDev(input logic v, output int cnt);
    cnt = 0;
    while (deviceReset !== v) begin
      tick(1);
      cnt++;
      if (cnt > 60) begin
        check(32'h0, 32'h1);
        give_verdict();
      end
    end
  endtask : waitDev

  function automatic logic [31:0] mkChain(input logic [7:0] id,
      input logic [7:0] o, input logic [7:0] e, input logic [7:0] p);
    logic [31:0] c;
    for (int k = 0; k < 8; k++) c[4*k +: 4] = {p[k], e[k], o[k], id[k]};
    return c;
  endfunction : mkChain

  task automatic loadIr(input logic [3:0] op);
    bst_jtag_ctl_i.scan(1'b1, 4, {28'h0, op}, dout);
    check(dout[3:0], 4'h1);
  endtask : loadIr

  task automatic t_id();
    bst_jtag_ctl_i.clrSeen();
    bst_jtag_ctl_i.scan(1'b0, 32, 32'h0, dout);
    check(dout, ID);
    check(oeSeen, 1'b1);
  endtask : t_id

  task automatic t_scan();
    pinIn = 8'h96;
    loadIr(4'h2);
    bst_jtag_ctl_i.scan(1'b0, 32, mkChain(8'h0, 8'ha5, 8'hff, 8'h5a), dout);
    check(dout, mkChain(8'h96, 8'h0, 8'h0, 8'h0));
    check({pinOut, pinOe, pinPud}, {sysOut, sysOe, sysPud});
    pinIn = 8'h69;
    loadIr(4'h0);
    check({pinOut, pinOe, pinPud}, {8'ha5, 8'hff, 8'h5a});
    bst_jtag_ctl_i.scan(1'b0, 32, mkChain(8'h0, 8'h0f, 8'h0f, 8'h0f), dout);
    check(dout, mkChain(8'h69, 8'ha5, 8'hff, 8'h5a));
    check({pinOut, pinOe, pinPud}, {8'h0f, 8'h0f, 8'h0f});
  endtask : t_scan

  task automatic t_bypass();
    logic [3:0] ops [5] = '{4'hf, 4'h3, 4'h7, 4'hd, 4'he};
    foreach (ops[i]) begin
      loadIr(ops[i]);
      bst_jtag_ctl_i.scan(1'b0, 8, 32'hb4, dout);
      check(dout[7:0], 8'h68);
    end
    bst_jtag_ctl_i.tapReset();
    t_id();
  endtask : t_bypass

  task automatic t_rst();
    int n;
    int su;
    loadIr(4'hc);
    for (int o = 0; o < 2; o++) begin
      tick(1);
      clkOptionLong = (o == 1);
      su = (o == 1) ? SU_L : SU_S;
      bst_jtag_ctl_i.scan(1'b0, 1, 32'h1, dout);
      check(pinOe, 8'h00);
      waitDev(1'b1, n);
      tick(1);
      check(testResetFlag, 1'b1);
      bst_jtag_ctl_i.scan(1'b0, 1, 32'h0, dout);
      check(dout[0], 1'b1);
      waitDev(1'b0, n);
      check(n >= su && n <= su + 5, 1'b1);
      flagWriteZero = 1'b1;
      tick(1);
      flagWriteZero = 1'b0;
      check(testResetFlag, 1'b0);
    end
  endtask : t_rst

  task automatic t_ext();
    int n;
    extResetN = 1'b0;
    waitDev(1'b1, n);
    check({pinOe, pinPud}, {8'h00, 8'hff});
    extResetN = 1'b1;
    waitDev(1'b0, n);
    check(testResetFlag, 1'b0);
  endtask : t_ext

  // Both disabling causes in turn; the TAP must come back at idcode
  task automatic t_dis();
    for (int i = 0; i < 2; i++) begin
      tick(1);
      fuse = (i == 1);
      disBit = (i == 1);
      bst_jtag_ctl_i.clrSeen();
      bst_jtag_ctl_i.scan(1'b0, 32, 32'h0, dout);
      check(oeSeen, 1'b0);
      tick(1);
      fuse = 1'b1;
      disBit = 1'b0;
      bst_jtag_ctl_i.tapReset();
      t_id();
    end
  endtask : t_dis

  initial begin
    int n;
    err_count = 0;
    num_checks = 0;
    rst = 1'b1;
    ce = 1'b1;
    fuse = 1'b1;
    disBit = 1'b0;
    extResetN = 1'b1;
    clkOptionLong = 1'b0;
    flagWriteZero = 1'b0;
    pinIn = 8'h00;
    sysOut = 8'h3c;
    sysOe = 8'hf0;
    sysPud = 8'h0f;
    fork
      repeat (16) @(posedge ref_clk);
      bst_jtag_ctl_i.tapReset();
    join
    #1;
    rst = 1'b0;
    bst_jtag_ctl_i.tapReset();
    waitDev(1'b0, n);
    t_id();
    t_scan();
    t_bypass();
    t_rst();
    t_ext();
    t_dis();
    give_verdict();
  end
endmodule : bst_tap_bench
`default_nettype wire
